//--- hw/uab_autobaud.sv
// times the first low pulse on the serial input
`timescale 1ns/100ps
`default_nettype none
module uab_autobaud
    import uab_pkg::*;
(
    // clock and reset
    input wire logic    aclk,
    input wire logic    aresetn,
    // control and line
    input wire logic    arm,
    input wire logic    rxd,
    // results
    output logic        fall,
    output logic        load,
    output logic        brk,
    output uab_div_t    est
);
    `include "uab_defines.svh"
    logic     rxd_d_r;
    logic     meas_r;
    uab_div_t cnt_r;

    assign fall = arm & rxd_d_r & ~rxd;
    assign load = meas_r & rxd & (cnt_r < `UAB_AB_MAX);
    assign brk  = meas_r & ~rxd & (cnt_r == `UAB_AB_BRK);
    // one bit is sixteen baud ticks, so the divisor is the width over 16
    assign est  = cnt_r >> 4;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxd_d_r <= 1'b1;
            meas_r  <= 1'b0;
            cnt_r   <= 16'h0000;
        end
        else
        begin
            rxd_d_r <= rxd;
            if (fall)
            begin
                meas_r <= 1'b1;
                cnt_r  <= 16'h0001;
            end
            else if (meas_r && rxd)
                meas_r <= 1'b0;
            else if (meas_r && cnt_r != `UAB_AB_SAT)
                cnt_r <= cnt_r + 16'h0001;
        end
    end

    property p_short_est;
        @(posedge aclk) disable iff (!aresetn)
        load && cnt_r < `UAB_AB_MIN |-> est <= 16'h0004;
    endproperty
    a_short_est: assert property (p_short_est) else $error("short pulse estimate too big");

    property p_brk_no_load;
        @(posedge aclk) disable iff (!aresetn)
        brk |-> ##1 (!load [*4]);
    endproperty
    a_brk_no_load: assert property (p_brk_no_load) else $error("load after break");
endmodule // uab_autobaud
`default_nettype wire

//--- hw/uab_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef UAB_DEFINES_SVH
`define UAB_DEFINES_SVH
// ****************
// read map
// ****************
`define UAB_RD_DATA     8'h00
`define UAB_RD_STAT1    8'h04
`define UAB_RD_STAT2    8'h08
`define UAB_RD_DIVLO    8'h0C
`define UAB_RD_DIVHI    8'h10
`define UAB_RD_CTRL5    8'h14
`define UAB_RD_CTRL4    8'h18
// ****************
// write map
// ****************
`define UAB_WR_CTRL2    8'h08
`define UAB_WR_DIVLO    8'h0C
`define UAB_WR_CTRL4    8'h10
`define UAB_WR_CTRL5    8'h14
`define UAB_WR_DIVHI    8'h18
// ****************
// fields and resets
// ****************
`define UAB_S1_CHP      3
`define UAB_S1_IRQ      4
`define UAB_S2_OVR      0
`define UAB_S2_BRK      1
`define UAB_C4_RXEN     0
`define UAB_C4_ARM      3
`define UAB_C4_TXAB     5
`define UAB_C5_IEN      6
`define UAB_C2_TEST     0
`define UAB_CTRL4_RST   8'h01
`define UAB_CTRL5_RST   8'h00
`define UAB_DIV_RST     16'h0040
`define UAB_RESP_OKAY   2'h0
`define UAB_RESP_SLVERR 2'h2
// ****************
// speed-matching limits in system clocks, receiver sample positions in baud ticks
// ****************
`define UAB_AB_MIN      16'h0048
`define UAB_AB_MAX      16'h8007
`define UAB_AB_BRK      16'h8008
`define UAB_AB_SAT      16'h8009
`define UAB_OS_MID      4'h7
`define UAB_OS_LAST     4'hF
`endif

//--- hw/uab_pkg.sv
// shared types of the receive status and speed-matching block
package uab_pkg;
    typedef logic [7:0]  uab_byte_t;
    typedef logic [15:0] uab_div_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uab_rx_state_t;
endpackage

//--- hw/uab_rx_queue.sv
// six-byte receive queue, oldest byte at index 0
`timescale 1ns/100ps
`default_nettype none
module uab_rx_queue
    import uab_pkg::*;
#(
    parameter int DEPTH = 6
)(
    // clock and reset
    input wire logic    aclk,
    input wire logic    aresetn,
    // queue port
    uab_rxq_if.queue    q
);
    uab_byte_t        mem_r [DEPTH];
    logic [DEPTH-1:0] vld_r;
    logic [DEPTH-1:0] vld_nxt;
    logic             bypass;
    logic             popv;
    logic             full;
    logic [2:0]       widx;

    function automatic logic [2:0] occ_count(input logic [DEPTH-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < DEPTH; i++)
            n = n + 3'(v[i]);
        return n;
    endfunction

    assign q.count   = occ_count(vld_r);
    assign bypass    = q.push & ~vld_r[0];
    assign q.head    = vld_r[0] ? mem_r[0] : q.push_data;
    assign popv      = q.pop & vld_r[0];
    assign full      = vld_r[DEPTH-1];
    // a full queue keeps its older bytes; the newest slot is overwritten
    assign widx      = (full & ~popv) ? 3'(DEPTH-1) : q.count - 3'(popv);
    assign q.ovr_evt = q.push & full & ~popv;

    always_comb
    begin
        vld_nxt = popv ? (vld_r >> 1) : vld_r;
        if (q.push & ~(q.pop & bypass))
            vld_nxt[widx] = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (q.push && 3'(i) == widx)
                mem_r[i] <= q.push_data;
            else if (popv && i < DEPTH-1)
                mem_r[i] <= mem_r[i+1];
        end
        vld_r <= (!aresetn || q.flush) ? '0 : vld_nxt;
    end

    // ****************
    // checks
    // ****************
    property p_count_up;
        @(posedge aclk) disable iff (!aresetn)
        q.push && !q.pop && !full && !q.flush |=> q.count == $past(q.count) + 3'h1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not grow");

    property p_oldest_first;
        @(posedge aclk) disable iff (!aresetn)
        popv && vld_r[1] && !q.flush |=> q.head == $past(mem_r[1]);
    endproperty
    a_oldest_first: assert property (p_oldest_first) else $error("wrong byte order");
endmodule // uab_rx_queue
`default_nettype wire

//--- hw/uab_rxq_if.sv
// receive queue carrier between the top and the queue
`timescale 1ns/100ps
`default_nettype none
interface uab_rxq_if import uab_pkg::*; ();
    logic      push;
    uab_byte_t push_data;
    logic      pop;
    logic      flush;
    uab_byte_t head;
    logic [2:0] count;
    logic      ovr_evt;
    modport queue (input push, push_data, pop, flush, output head, count, ovr_evt);
    modport user  (output push, push_data, pop, flush, input head, count, ovr_evt);
endinterface
`default_nettype wire

//--- hw/uab_top.sv
// receive status, receive queue and speed matching with an AXI4-Lite register slave
//
// Notes on behaviour
// - queue occupancy flags encode to a 3-bit byte count in status register
// - count at or above threshold with interrupt enabled drives irq low; an empty queue never does
// - character-present bit is set while the queue holds any byte
// - a data read, allowed any time, returns the oldest queued byte
// - a byte arriving during the read still yields the correct oldest byte
// - host uses strobed bus accesses; device latches the address when offered
// - first falling edge on the serial input clears the arm bit
// - pulse of 72 to 32774 clocks loads divisor estimate, readable afterwards
// - interrupt mode 000 raises latched interrupt at end of first pulse
// - latched speed-match interrupt holds until host writes arm bit zero
// - pulse over 32776 clocks reports break, no estimate, no interrupt
// - pulse under 72 clocks still loads a useless divisor and interrupts
// - a zero divisor stops the baud generator, disabling reception
// - during reset the irq pin is released (rx_irq_oe low, rx_irq_n high); tx_abort and bus outputs drive low
// - reset empties the queue, clears status and restores control defaults
// - queue holds six bytes behind one receive shift register
// - each serial bit lasts sixteen baud-generator ticks
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module uab_top
    import uab_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // serial line and pins
    input  wire logic              rxd,
    output logic                   rx_irq_n,
    output logic                   rx_irq_oe,
    output logic                   tx_abort
);
    `include "uab_defines.svh"

    // ****************
    // declarations
    // ****************
    uab_rxq_if q ();
    logic            rxd_m_r;
    logic            rxd_s_r;
    logic            aw_full_r, w_full_r;
    logic [ADDR_W-1:0] aw_addr_r;
    uab_byte_t       w_data_r;
    logic            w_lane_r;
    logic            aw_take, w_take, wr_fire, ar_take;
    logic            aw_full_nxt, w_full_nxt, bvalid_nxt, rvalid_nxt;
    logic            wr_ok, wr_c2, wr_c4, wr_c5, wr_dlo, wr_dhi;
    logic            rd_map, rd_pop;
    uab_byte_t       rd_byte;
    uab_div_t        div_r;
    logic            rxen_r, arm_r, test2_r;
    logic [2:0]      thr_r, mode_r;
    logic            ien_r;
    logic            sm_irq_r, ovr_r, brk_r;
    logic            lvl_hit, sm_clr, irq_act;
    logic            ab_fall, ab_load, ab_brk;
    uab_div_t        ab_est;
    uab_div_t        bcnt_r;
    logic            tick;
    uab_rx_state_t   st_r;
    logic [3:0]      os_r;
    logic [2:0]      bit_r;
    uab_byte_t       sh_r;
    logic            rx_push_r;
    uab_byte_t       rx_byte_r;
    logic            rx_brk, rx_one;
    uab_byte_t       stat1, stat2, ctrl4, ctrl5;

    // ****************
    // line synchroniser
    // ****************
    always_ff @(posedge aclk)
    begin
        rxd_m_r <= aresetn ? rxd : 1'b1;
        rxd_s_r <= aresetn ? rxd_m_r : 1'b1;
    end

    // ****************
    // axi4-lite write path
    // ****************
    assign aw_take     = awvalid & awready;
    assign w_take      = wvalid & wready;
    assign wr_fire     = aw_full_r & w_full_r & ~bvalid;
    assign aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
    assign w_full_nxt  = (w_full_r | w_take) & ~wr_fire;
    assign bvalid_nxt  = wr_fire | (bvalid & ~bready);
    assign wr_ok       = wr_fire & w_lane_r;
    assign wr_c2       = wr_ok & (aw_addr_r == `UAB_WR_CTRL2);
    assign wr_dlo      = wr_ok & (aw_addr_r == `UAB_WR_DIVLO);
    assign wr_c4       = wr_ok & (aw_addr_r == `UAB_WR_CTRL4);
    assign wr_c5       = wr_ok & (aw_addr_r == `UAB_WR_CTRL5);
    assign wr_dhi      = wr_ok & (aw_addr_r == `UAB_WR_DIVHI);

    always_ff @(posedge aclk)
    begin
        if (aw_take)
            aw_addr_r <= awaddr;
        if (w_take)
        begin
            w_data_r <= wdata[7:0];
            w_lane_r <= wstrb[0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `UAB_RESP_OKAY;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            awready   <= ~aw_full_nxt & ~bvalid_nxt;
            wready    <= ~w_full_nxt & ~bvalid_nxt;
            bvalid    <= bvalid_nxt;
            if (wr_fire)
                bresp <= (wr_c2 | wr_dlo | wr_c4 | wr_c5 | wr_dhi | ~w_lane_r) ?
                         `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
        end
    end

    // ****************
    // axi4-lite read path
    // ****************
    assign ar_take    = arvalid & arready;
    assign rvalid_nxt = ar_take | (rvalid & ~rready);
    assign rd_pop     = ar_take & (araddr == `UAB_RD_DATA);
    assign stat1      = {3'h0, irq_n_view(irq_act), q.count != 3'h0, q.count};
    assign stat2      = {6'h00, brk_r, ovr_r};
    assign ctrl4      = {2'h0, tx_abort, 1'b0, arm_r, 2'h0, rxen_r};
    assign ctrl5      = {1'b0, ien_r, mode_r, thr_r};
    assign rd_map     = (araddr == `UAB_RD_DATA)  | (araddr == `UAB_RD_STAT1) |
                        (araddr == `UAB_RD_STAT2) | (araddr == `UAB_RD_DIVLO) |
                        (araddr == `UAB_RD_DIVHI) | (araddr == `UAB_RD_CTRL5) |
                        (araddr == `UAB_RD_CTRL4);
    assign rd_byte    = (araddr == `UAB_RD_DATA)  ? (q.count != 3'h0 || q.push ? q.head : 8'h00) :
                        (araddr == `UAB_RD_STAT1) ? stat1 :
                        (araddr == `UAB_RD_STAT2) ? stat2 :
                        (araddr == `UAB_RD_DIVLO) ? div_r[7:0] :
                        (araddr == `UAB_RD_DIVHI) ? div_r[15:8] :
                        (araddr == `UAB_RD_CTRL5) ? ctrl5 :
                        (araddr == `UAB_RD_CTRL4) ? ctrl4 : 8'h00;

    // status shows the interrupt as a low-true level, like the pin
    function automatic logic irq_n_view(input logic act);
        return ~act;
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `UAB_RESP_OKAY;
        end
        else
        begin
            arready <= ~rvalid_nxt;
            rvalid  <= rvalid_nxt;
            if (ar_take)
            begin
                rdata <= {24'h00_0000, rd_byte};
                rresp <= rd_map ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
            end
        end
    end

    // ****************
    // control registers
    // ****************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxen_r   <= 1'(`UAB_CTRL4_RST >> `UAB_C4_RXEN);
            arm_r    <= 1'b0;
            tx_abort <= 1'b0;
            test2_r  <= 1'b0;
            {ien_r, mode_r, thr_r} <= 7'(`UAB_CTRL5_RST);
            div_r    <= `UAB_DIV_RST;
        end
        else
        begin
            if (wr_c4)
            begin
                rxen_r   <= w_data_r[`UAB_C4_RXEN];
                arm_r    <= w_data_r[`UAB_C4_ARM];
                tx_abort <= w_data_r[`UAB_C4_TXAB];
            end
            else if (ab_fall)
                arm_r <= 1'b0;
            if (wr_c2)
                test2_r <= w_data_r[`UAB_C2_TEST];
            if (wr_c5)
                {ien_r, mode_r, thr_r} <= w_data_r[6:0];
            if (ab_load)
                div_r <= ab_est;
            else if (wr_dlo)
                div_r[7:0] <= w_data_r;
            else if (wr_dhi)
                div_r[15:8] <= w_data_r;
        end
    end

    // ****************
    // speed matching
    // ****************
    uab_autobaud u_ab (
        .aclk    (aclk),
        .aresetn (aresetn),
        .arm     (arm_r),
        .rxd     (rxd_s_r),
        .fall    (ab_fall),
        .load    (ab_load),
        .brk     (ab_brk),
        .est     (ab_est)
    );

    // ****************
    // status flags and interrupt pin
    // ****************
    assign lvl_hit = ien_r & (q.count != 3'h0) & (q.count >= thr_r);
    assign sm_clr  = wr_c4 & ~w_data_r[`UAB_C4_ARM];
    assign irq_act = lvl_hit | sm_irq_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sm_irq_r  <= 1'b0;
            ovr_r     <= 1'b0;
            brk_r     <= 1'b0;
            rx_irq_n  <= 1'b1;
            rx_irq_oe <= 1'b0;
        end
        else
        begin
            // a new event in the clearing cycle wins
            if (ab_load && ien_r && mode_r == 3'h0)
                sm_irq_r <= 1'b1;
            else if (sm_clr)
                sm_irq_r <= 1'b0;
            if (q.ovr_evt)
                ovr_r <= 1'b1;
            else if (rd_pop)
                ovr_r <= 1'b0;
            if (ab_brk || rx_brk)
                brk_r <= 1'b1;
            else if (rx_one)
                brk_r <= 1'b0;
            rx_irq_n  <= ~irq_act;
            rx_irq_oe <= 1'b1;
        end
    end

    // ****************
    // baud generator and receiver
    // ****************
    // a zero divisor never ticks, which stops reception altogether
    // a counter left above a newly written divisor ticks at once instead of wrapping
    assign tick   = (div_r != 16'h0000) & (bcnt_r >= div_r - 16'h0001);
    assign rx_brk = tick & (st_r == RX_STOP) & (os_r == `UAB_OS_LAST) & ~rxd_s_r & (sh_r == 8'h00);
    assign rx_one = tick & (os_r == `UAB_OS_LAST) & rxd_s_r & (st_r inside {RX_DATA, RX_STOP});

    always_ff @(posedge aclk)
    begin
        if (!aresetn || div_r == 16'h0000 || tick || ab_load)
            bcnt_r <= 16'h0000;
        else
            bcnt_r <= bcnt_r + 16'h0001;
    end

    always_ff @(posedge aclk)
    begin
        rx_push_r <= 1'b0;
        if (!aresetn || !rxen_r || arm_r)
            st_r <= RX_IDLE;
        else if (ab_load)
        begin
            // line rose at the end of the start bit, so data bits follow
            st_r  <= RX_DATA;
            os_r  <= 4'h8;
            bit_r <= 3'h0;
        end
        else if (tick)
        begin
            os_r <= os_r + 4'h1;
            unique case (st_r)
                RX_IDLE:
                begin
                    os_r <= 4'h0;
                    if (!rxd_s_r)
                        st_r <= RX_START;
                end
                RX_START:
                    if (os_r == `UAB_OS_MID)
                    begin
                        os_r  <= 4'h0;
                        bit_r <= 3'h0;
                        st_r  <= rxd_s_r ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (os_r == `UAB_OS_LAST)
                    begin
                        sh_r  <= {rxd_s_r, sh_r[7:1]};
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7)
                            st_r <= RX_STOP;
                    end
                RX_STOP:
                    if (os_r == `UAB_OS_LAST)
                    begin
                        st_r      <= RX_IDLE;
                        rx_push_r <= ~rx_brk;
                        rx_byte_r <= sh_r;
                    end
            endcase
        end
    end

    // ****************
    // receive queue
    // ****************
    assign q.push      = rx_push_r;
    assign q.push_data = rx_byte_r;
    assign q.pop       = rd_pop;
    assign q.flush     = 1'b0;

    uab_rx_queue #(
        .DEPTH (6)
    ) u_q (
        .aclk    (aclk),
        .aresetn (aresetn),
        .q       (q.queue)
    );

    // ****************
    // checks
    // ****************
    property p_irq_level;
        @(posedge aclk) disable iff (!aresetn)
        lvl_hit |=> !rx_irq_n;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not low at threshold");

    property p_char_present;
        @(posedge aclk) disable iff (!aresetn)
        ar_take && araddr == `UAB_RD_STAT1 |=> rdata[`UAB_S1_CHP] == ($past(q.count) != 3'h0);
    endproperty
    a_char_present: assert property (p_char_present) else $error("char present wrong");

    property p_arm_clear;
        @(posedge aclk) disable iff (!aresetn)
        ab_fall && !wr_c4 |=> !arm_r;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm not cleared");

    property p_div_load;
        @(posedge aclk) disable iff (!aresetn)
        ab_load |=> div_r == $past(ab_est);
    endproperty
    a_div_load: assert property (p_div_load) else $error("estimate not loaded");

    property p_sm_hold;
        @(posedge aclk) disable iff (!aresetn)
        sm_irq_r && !sm_clr |=> sm_irq_r && !rx_irq_n;
    endproperty
    a_sm_hold: assert property (p_sm_hold) else $error("latched irq dropped");

    property p_zero_div;
        @(posedge aclk) disable iff (!aresetn)
        div_r == 16'h0000 |-> !tick;
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("tick with zero divisor");

    property p_reset_release;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> !rx_irq_oe && rx_irq_n && !bvalid && !rvalid;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("outputs active in reset");
endmodule // uab_top
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench of the receive status and speed-matching block
`timescale 1ns/100ps
`default_nettype none
`include "uab_defines.svh"
module testbench;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rxd;
    logic        awready, wready, bvalid, arready, rvalid, rx_irq_n, rx_irq_oe, tx_abort;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata, rdata, rd_data;
    logic [1:0]  bresp, rresp, rd_resp, wr_resp;
    int          err_total, samples_checked, cyc;
    uab_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .rxd, .rx_irq_n, .rx_irq_oe, .tx_abort);
    uab_line_tx u_tx (.aclk, .rxd);
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // the longest pulse needs about 33000 cycles
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), rd_data, e);
    endtask
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        chk("irq_oe", rx_irq_oe, 0);
        aresetn <= 1'b1;
        rc(`UAB_RD_CTRL4, 8'h01);
        rc(`UAB_RD_STAT1, 8'h10);
        rc(`UAB_RD_DIVLO, 8'h40);
        chk("tx_abort", tx_abort, 0);
        chk("irq_oe", rx_irq_oe, 1);
        rd(8'hFC);
        chk("rresp", rd_resp, `UAB_RESP_SLVERR);
        wr(8'hFC, 8'h00);
        chk("bresp", wr_resp, `UAB_RESP_SLVERR);
        wr(`UAB_WR_CTRL2, 8'h00);
        chk("bresp", wr_resp, `UAB_RESP_OKAY);
        wr(`UAB_WR_DIVLO, 8'h02);
        wr(`UAB_WR_CTRL5, 8'h43);
        for (int i = 0; i < 3; i++) u_tx.send(8'hA0 + 8'(i), 2);
        u_tx.hold(1'b1, 32);
        rc(`UAB_RD_STAT1, 8'h0B);
        chk("irq", rx_irq_n, 0);
        for (int i = 0; i < 3; i++) rc(`UAB_RD_DATA, 32'hA0 + i);
        rc(`UAB_RD_STAT1, 8'h10);
        // too short a pulse still loads a divisor and interrupts
        wr(`UAB_WR_CTRL4, 8'h09);
        u_tx.hold(1'b0, 64);
        // long enough for the all-ones byte at the new divisor to land
        u_tx.hold(1'b1, 600);
        chk("irq", rx_irq_n, 0);
        rc(`UAB_RD_DIVLO, 8'h04);
        wr(`UAB_WR_CTRL4, 8'h01);
        rd(`UAB_RD_DATA);
        wr(`UAB_WR_CTRL4, 8'h09);
        u_tx.hold(1'b0, 33000);
        rc(`UAB_RD_STAT2, 8'h02);
        u_tx.hold(1'b1, 40);
        chk("irq", rx_irq_n, 1);
        rc(`UAB_RD_DIVLO, 8'h04);
        wr(`UAB_WR_CTRL4, 8'h09);
        u_tx.hold(1'b0, 8);
        u_tx.hold(1'b1, 40);
        rc(`UAB_RD_DIVLO, 8'h00);
        wr(`UAB_WR_CTRL4, 8'h01);
        // drain a byte that the tail of the break may have completed
        rd(`UAB_RD_DATA);
        u_tx.send(8'h55, 2);
        rc(`UAB_RD_STAT1, 8'h10);
        wr(`UAB_WR_CTRL4, 8'h29);
        chk("tx_abort", tx_abort, 1);
        u_tx.hold(1'b0, 1608);
        u_tx.hold(1'b1, 40);
        rc(`UAB_RD_DIVLO, 8'h64);
        rc(`UAB_RD_DIVHI, 8'h00);
        rc(`UAB_RD_CTRL4, 8'h21);
        chk("irq", rx_irq_n, 0);
        wr(`UAB_WR_DIVLO, 8'h65);
        rc(`UAB_RD_DIVLO, 8'h65);
        wr(`UAB_WR_CTRL4, 8'h01);
        rc(`UAB_RD_STAT1, 8'h10);
        chk("irq", rx_irq_n, 1);
        stop_test();
    end
endmodule // testbench
`default_nettype wire

//--- testbench/uab_line_tx.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module uab_line_tx (
    // clock and line
    input wire logic aclk,
    output logic     rxd
);
    initial rxd = 1'b1;
    task automatic hold(input logic b, input int n);
        rxd <= b;
        repeat (n) @(posedge aclk);
    endtask
    // start, eight data bits lsb first, stop
    task automatic send(input logic [7:0] d, input int tick);
        hold(1'b0, 16 * tick);
        for (int i = 0; i < 8; i++) hold(d[i], 16 * tick);
        hold(1'b1, 16 * tick);
    endtask
endmodule // uab_line_tx
`default_nettype wire
